/* File: include/rtma_defs.svh */
// constants for the radio terminal message arbiter
// Summary of operation
// - four modes: printer, vehicle-location, converter, terminal priority
// - terminal priority is the default mode
// - printer mode forwards radio data, no codes
// - printer drops the rest of the message after a receive error
// - vehicle-location mode uses radio address 15, not 6
// - anti-bias adds 12.5% air overhead, 512 bytes
// - anti-bias enabled by a jumper input
// - terminal priority collision: accept, hold inbound, receive
// - completion code first, then inbound transfer request
// - early second request: accept then abort at once
// - reject radio inbound calls while inbound held
// - terminal request during inbound receive is a collision
// - after radio abort: finish receive, abort, discard
// - inbound complete: send transfer request to terminal
`ifndef RTMA_DEFS_SVH
`define RTMA_DEFS_SVH

// option jumper encodings; all-zero is the factory setting
`define RTMA_MODE_TERM 2'h0
`define RTMA_MODE_CONV 2'h1
`define RTMA_MODE_VLOC 2'h2
`define RTMA_MODE_PRINT 2'h3

// radio addresses
`define RTMA_ADDR_NORMAL 4'h6
`define RTMA_ADDR_VLOC 4'hF

// message sizes
`define RTMA_MSG_MAX 512
`define RTMA_LEN_W 10
`define RTMA_FIFO_DEPTH 16
`define RTMA_BYTE_W 8

// anti-bias overhead is one byte in eight
`define RTMA_BIAS_SHIFT 3
`define RTMA_BIAS_ROUND 10'h007

// codes sent to the terminal
`define RTMA_CODE_ACCEPT 2'h0
`define RTMA_CODE_ABORT 2'h1
`define RTMA_CODE_SUCCESS 2'h2
`define RTMA_CODE_XFER 2'h3

`endif

/* File: include/rtma_pkg.sv */
// types shared by the arbiter modules
`include "rtma_defs.svh"
package rtma_pkg;
  // inbound path states
  typedef enum logic [2:0] {
    RTMA_IN_IDLE,
    RTMA_IN_RECV,
    RTMA_IN_HELD,
    RTMA_IN_REQ,
    RTMA_IN_SEND
  } rtma_in_state_t;
  // outbound path states
  typedef enum logic [1:0] {
    RTMA_OUT_IDLE,
    RTMA_OUT_ACTIVE,
    RTMA_OUT_CALL
  } rtma_out_state_t;
endpackage

/* File: core/rtma_fifo.sv */
// byte fifo in front of the terminal output
`timescale 1ns/1ns
module rtma_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW-1:0] wr_ptr; // write index
  logic [AW-1:0] rd_ptr; // read index
  logic [AW:0] count; // words held
  logic push;
  logic pop;

  // honest full and empty
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // rtma_fifo

/* File: core/rtma_msg_buf.sv */
// one whole-message byte buffer
`timescale 1ns/1ns
module rtma_msg_buf #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  // clock
  input wire logic sys_clk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port, combinational
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH]; // message bytes

  // write one byte
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read without latency so handshakes stay simple
  assign rd_data = mem[rd_addr];
endmodule // rtma_msg_buf

/* File: core/rtma_arbiter.sv */
// message arbiter between a serial data terminal and a radio control bus
`timescale 1ns/1ns
`include "rtma_defs.svh"
module rtma_arbiter
  import rtma_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // option and anti-bias jumpers
  input wire logic [1:0] mode_jumper,
  input wire logic anti_bias_jumper,
  // terminal: transfer request and accept from terminal
  input wire logic term_xfer_req,
  input wire logic term_accept,
  // terminal: codes to terminal
  output logic term_code_valid,
  output logic [1:0] term_code,
  input wire logic term_code_ready,
  // terminal: outbound message bytes
  input wire logic term_rx_valid,
  input wire logic [7:0] term_rx_data,
  input wire logic term_rx_last,
  output logic term_rx_ready,
  // terminal: inbound message bytes (also printer output)
  output logic term_tx_valid,
  output logic [7:0] term_tx_data,
  output logic term_tx_last,
  input wire logic term_tx_ready,
  // radio: inbound call offer and answer
  input wire logic radio_offer,
  output logic radio_offer_ok,
  output logic radio_offer_reject,
  // radio: inbound message bytes
  input wire logic radio_rx_valid,
  input wire logic [7:0] radio_rx_data,
  input wire logic radio_rx_last,
  input wire logic radio_rx_err,
  output logic radio_rx_ready,
  // radio: outbound message bytes
  output logic radio_tx_valid,
  output logic [7:0] radio_tx_data,
  output logic radio_tx_last,
  input wire logic radio_tx_ready,
  // radio: outbound abort and call result
  input wire logic radio_tx_abort,
  input wire logic radio_call_ok,
  input wire logic radio_call_fail,
  // radio: addressing and air coding
  output logic [3:0] radio_addr,
  output logic anti_bias_on,
  output logic [`RTMA_LEN_W:0] air_len
);
  localparam int AW = `RTMA_LEN_W - 1; // buffer address width

  // state
  rtma_in_state_t in_state; // inbound path
  rtma_out_state_t out_state; // outbound path
  logic [`RTMA_LEN_W-1:0] in_len; // inbound bytes held
  logic [`RTMA_LEN_W-1:0] in_rd; // inbound bytes delivered
  logic [`RTMA_LEN_W-1:0] out_len; // outbound bytes held
  logic [`RTMA_LEN_W-1:0] out_rd; // outbound bytes sent to radio
  logic out_term_done; // terminal finished its message
  logic out_aborted; // radio dropped the outbound transfer
  logic collided; // inbound held because of a collision
  logic pend_accept; // accept code owed
  logic pend_done; // completion code owed
  logic done_abort; // completion is abort rather than success
  logic print_drop; // printer discarding after an error
  logic [1:0] mode; // registered option mode

  // derived
  logic is_print;
  logic is_conv;
  logic pend_xfer;
  logic code_fire;
  logic req_collide;
  logic req_early;
  logic req_take;
  logic [7:0] in_rd_data;
  logic [7:0] out_rd_data;
  logic in_wr;
  logic out_wr;
  logic fifo_in_valid;
  logic [8:0] fifo_in_data;
  logic fifo_in_ready;
  logic [8:0] fifo_out_data;

  // grow a length by one eighth, rounded up
  function automatic logic [`RTMA_LEN_W:0] bias_len(input logic [`RTMA_LEN_W-1:0] n);
    bias_len = {1'b0, n} + (`RTMA_LEN_W+1)'((n + `RTMA_BIAS_ROUND) >> `RTMA_BIAS_SHIFT);
  endfunction

  assign is_print = (mode == `RTMA_MODE_PRINT);
  assign is_conv = (mode == `RTMA_MODE_CONV);

  // jumpers are sampled every cycle; changing them mid-message is not supported
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode <= `RTMA_MODE_TERM;
      anti_bias_on <= 1'b0;
      radio_addr <= `RTMA_ADDR_NORMAL;
    end else begin
      mode <= mode_jumper;
      anti_bias_on <= anti_bias_jumper;
      radio_addr <= (mode_jumper == `RTMA_MODE_VLOC) ? `RTMA_ADDR_VLOC : `RTMA_ADDR_NORMAL;
    end
  end

  // classify a terminal transfer request
  // early: our own request is still owed after an earlier collision
  assign req_early = collided && (in_state == RTMA_IN_HELD) && (out_state == RTMA_OUT_IDLE);
  // collision: our request is out, or inbound data is still arriving
  assign req_collide = (in_state == RTMA_IN_REQ) || (in_state == RTMA_IN_RECV);
  // converter priority leaves a terminal request unanswered while our transfer request is out
  assign req_take = term_xfer_req && !is_print && !pend_accept && (out_state == RTMA_OUT_IDLE)
                    && !(is_conv && in_state == RTMA_IN_REQ);

  // codes: accept, then completion, then our own transfer request
  assign pend_xfer = (in_state == RTMA_IN_HELD) && !is_print && (out_state == RTMA_OUT_IDLE) && !pend_done;
  assign term_code_valid = pend_accept || pend_done || pend_xfer;
  always_comb begin
    if (pend_accept) begin
      term_code = `RTMA_CODE_ACCEPT;
    end else if (pend_done) begin
      term_code = done_abort ? `RTMA_CODE_ABORT : `RTMA_CODE_SUCCESS;
    end else begin
      term_code = `RTMA_CODE_XFER;
    end
  end
  assign code_fire = term_code_valid && term_code_ready;

  // accept code owed to the terminal
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pend_accept <= 1'b0;
    end else if (req_take) begin
      pend_accept <= 1'b1;
    end else if (code_fire && pend_accept) begin
      pend_accept <= 1'b0;
    end
  end

  // completion code owed to the terminal
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pend_done <= 1'b0;
      done_abort <= 1'b0;
    end else if (req_take && req_early) begin
      pend_done <= 1'b1;
      done_abort <= 1'b1;
    end else if (out_state == RTMA_OUT_ACTIVE && out_aborted && out_term_done) begin
      pend_done <= 1'b1;
      done_abort <= 1'b1;
    end else if (out_state == RTMA_OUT_CALL && (radio_call_ok || radio_call_fail)) begin
      pend_done <= 1'b1;
      done_abort <= radio_call_fail;
    end else if (code_fire && !pend_accept && pend_done) begin
      pend_done <= 1'b0;
    end
  end

  // collision memory, cleared once the held message is delivered
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      collided <= 1'b0;
    end else if (req_take && req_collide && !is_conv) begin
      collided <= 1'b1;
    end else if (in_state == RTMA_IN_IDLE) begin
      collided <= 1'b0;
    end
  end

  // radio offers: taken in printer mode or with an empty inbound buffer
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      radio_offer_ok <= 1'b0;
      radio_offer_reject <= 1'b0;
    end else begin
      radio_offer_ok <= radio_offer && (is_print || in_state == RTMA_IN_IDLE);
      radio_offer_reject <= radio_offer && !is_print && (in_state != RTMA_IN_IDLE);
    end
  end

  // inbound writes; bytes past the buffer size are dropped
  assign radio_rx_ready = is_print ? (fifo_in_ready || print_drop) : (in_state == RTMA_IN_RECV);
  assign in_wr = !is_print && radio_rx_valid && (in_state == RTMA_IN_RECV)
                 && (in_len < `RTMA_LEN_W'(`RTMA_MSG_MAX));

  // inbound path sequence
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      in_state <= RTMA_IN_IDLE;
    end else begin
      case (in_state)
        RTMA_IN_IDLE: begin
          if (radio_offer && !is_print) begin
            in_state <= RTMA_IN_RECV;
          end
        end
        RTMA_IN_RECV: begin
          if (radio_rx_valid && radio_rx_last) begin
            in_state <= RTMA_IN_HELD;
          end
        end
        RTMA_IN_HELD: begin
          if (code_fire && !pend_accept && !pend_done) begin
            in_state <= RTMA_IN_REQ;
          end
        end
        RTMA_IN_REQ: begin
          if (req_take) begin
            in_state <= RTMA_IN_HELD;
          end else if (term_accept) begin
            in_state <= RTMA_IN_SEND;
          end
        end
        RTMA_IN_SEND: begin
          if (fifo_in_valid && fifo_in_ready && fifo_in_data[8]) begin
            in_state <= RTMA_IN_IDLE;
          end
        end
        default: in_state <= RTMA_IN_IDLE;
      endcase
    end
  end

  // inbound counters
  always_ff @(posedge sys_clk) begin
    if (!rstn || in_state == RTMA_IN_IDLE) begin
      in_len <= '0;
      in_rd <= '0;
    end else begin
      if (in_wr) begin
        in_len <= in_len + 1'b1;
      end
      if (in_state == RTMA_IN_SEND && fifo_in_ready) begin
        in_rd <= in_rd + 1'b1;
      end
    end
  end

  // printer discard after a receive error, until message end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      print_drop <= 1'b0;
    end else if (is_print && radio_rx_valid && radio_rx_last) begin
      print_drop <= 1'b0;
    end else if (is_print && radio_rx_valid && radio_rx_err) begin
      print_drop <= 1'b1;
    end
  end

  // fifo source: radio directly in printer mode, else the inbound buffer
  always_comb begin
    if (is_print) begin
      fifo_in_valid = radio_rx_valid && !radio_rx_err && !print_drop;
      fifo_in_data = {radio_rx_last, radio_rx_data};
    end else begin
      fifo_in_valid = (in_state == RTMA_IN_SEND);
      fifo_in_data = {(in_rd + 1'b1 >= in_len), in_rd_data};
    end
  end

  // outbound path accepts terminal bytes while sending to the radio
  assign term_rx_ready = (out_state == RTMA_OUT_ACTIVE) && !out_term_done
                         && (out_len < `RTMA_LEN_W'(`RTMA_MSG_MAX));
  assign out_wr = term_rx_valid && term_rx_ready;
  assign radio_tx_valid = (out_state == RTMA_OUT_ACTIVE) && !out_aborted && (out_rd < out_len);
  assign radio_tx_data = out_rd_data;
  assign radio_tx_last = out_term_done && (out_rd + 1'b1 == out_len);

  // outbound path sequence
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      out_state <= RTMA_OUT_IDLE;
    end else begin
      case (out_state)
        RTMA_OUT_IDLE: begin
          if (req_take && !req_early) begin
            out_state <= RTMA_OUT_ACTIVE;
          end
        end
        RTMA_OUT_ACTIVE: begin
          if (out_aborted && out_term_done) begin
            out_state <= RTMA_OUT_IDLE;
          end else if (radio_tx_valid && radio_tx_ready && radio_tx_last) begin
            out_state <= RTMA_OUT_CALL;
          end
        end
        RTMA_OUT_CALL: begin
          if (radio_call_ok || radio_call_fail) begin
            out_state <= RTMA_OUT_IDLE;
          end
        end
        default: out_state <= RTMA_OUT_IDLE;
      endcase
    end
  end

  // outbound counters and flags; idle discards the message
  always_ff @(posedge sys_clk) begin
    if (!rstn || out_state == RTMA_OUT_IDLE) begin
      out_len <= '0;
      out_rd <= '0;
      out_term_done <= 1'b0;
      out_aborted <= 1'b0;
    end else begin
      if (out_wr) begin
        out_len <= out_len + 1'b1;
      end
      if (out_wr && term_rx_last) begin
        out_term_done <= 1'b1;
      end
      if (radio_tx_valid && radio_tx_ready) begin
        out_rd <= out_rd + 1'b1;
      end
      if (radio_tx_abort && out_state == RTMA_OUT_ACTIVE) begin
        out_aborted <= 1'b1;
      end
    end
  end

  // air length of the outbound message, with anti-bias overhead
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      air_len <= '0;
    end else begin
      air_len <= anti_bias_on ? bias_len(out_len) : {1'b0, out_len};
    end
  end

  // inbound message store
  rtma_msg_buf #(.DEPTH(`RTMA_MSG_MAX), .AW(AW)) u_in_buf (
    .sys_clk(sys_clk),
    .wr_en(in_wr),
    .wr_addr(in_len[AW-1:0]),
    .wr_data(radio_rx_data),
    .rd_addr(in_rd[AW-1:0]),
    .rd_data(in_rd_data)
  );

  // outbound message store, separate so both survive a collision
  rtma_msg_buf #(.DEPTH(`RTMA_MSG_MAX), .AW(AW)) u_out_buf (
    .sys_clk(sys_clk),
    .wr_en(out_wr),
    .wr_addr(out_len[AW-1:0]),
    .wr_data(term_rx_data),
    .rd_addr(out_rd[AW-1:0]),
    .rd_data(out_rd_data)
  );

  // terminal output fifo; a slow terminal stalls delivery
  rtma_fifo #(.WIDTH(9), .DEPTH(`RTMA_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_data),
    .in_ready(fifo_in_ready),
    .out_valid(term_tx_valid),
    .out_data(fifo_out_data),
    .out_ready(term_tx_ready)
  );
  assign term_tx_data = fifo_out_data[7:0];
  assign term_tx_last = fifo_out_data[8];
endmodule // rtma_arbiter

/* File: tb/rtma_arbiter_asserts.sv */
// port-level checks for the message arbiter
`timescale 1ns/1ns
`include "rtma_defs.svh"
module rtma_arbiter_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // jumpers
  input wire logic [1:0] mode_jumper,
  input wire logic anti_bias_jumper,
  // terminal side
  input wire logic term_code_valid,
  input wire logic [1:0] term_code,
  input wire logic term_code_ready,
  input wire logic term_rx_ready,
  input wire logic term_tx_valid,
  input wire logic [7:0] term_tx_data,
  input wire logic term_tx_ready,
  // radio side
  input wire logic radio_offer,
  input wire logic radio_offer_ok,
  input wire logic radio_offer_reject,
  input wire logic [3:0] radio_addr,
  input wire logic anti_bias_on
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // a code that waits for the terminal keeps its value
  sequence s_code_stall;
    term_code_valid && !term_code_ready;
  endsequence
  sequence s_code_same;
    term_code_valid && $stable(term_code);
  endsequence
  property p_code_hold;
    s_code_stall |=> s_code_same;
  endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("code changed before taken");
  // address follows the option jumper one edge later
  property p_addr;
    $past(rstn) |-> radio_addr == (($past(mode_jumper) == `RTMA_MODE_VLOC) ? `RTMA_ADDR_VLOC : `RTMA_ADDR_NORMAL);
  endproperty
  a_addr: assert property (p_addr)
    else $error("radio address wrong for mode");
  property p_bias;
    $past(rstn) |-> anti_bias_on == $past(anti_bias_jumper);
  endproperty
  a_bias: assert property (p_bias)
    else $error("coding flag does not follow jumper");
  // every offer gets exactly one answer, one cycle later
  property p_offer_ans;
    radio_offer |=> radio_offer_ok != radio_offer_reject;
  endproperty
  a_offer_ans: assert property (p_offer_ans)
    else $error("offer not answered once");
  property p_offer_cause;
    (radio_offer_ok || radio_offer_reject) |-> $past(radio_offer);
  endproperty
  a_offer_cause: assert property (p_offer_cause)
    else $error("answer without offer");
  // printer mode takes every offer and sends no codes
  property p_print_ok;
    mode_jumper == `RTMA_MODE_PRINT && $past(mode_jumper) == `RTMA_MODE_PRINT && radio_offer |=> radio_offer_ok;
  endproperty
  a_print_ok: assert property (p_print_ok)
    else $error("printer offer refused");
  property p_print_nocode;
    mode_jumper == `RTMA_MODE_PRINT && $past(mode_jumper) == `RTMA_MODE_PRINT |-> !term_code_valid;
  endproperty
  a_print_nocode: assert property (p_print_nocode)
    else $error("code sent in printer mode");
  property p_tx_hold;
    term_tx_valid && !term_tx_ready |=> term_tx_valid && $stable(term_tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("terminal byte lost under stall");
  // our transfer request never overlaps an open outbound transfer
  property p_xfer_excl;
    term_code_valid && term_code == `RTMA_CODE_XFER |-> !term_rx_ready;
  endproperty
  a_xfer_excl: assert property (p_xfer_excl)
    else $error("transfer request during outbound");
endmodule // rtma_arbiter_asserts
bind rtma_arbiter rtma_arbiter_asserts rtma_arbiter_asserts_inst (.*);

/* File: tb/rtma_radio_model.sv */
// behavioural radio facing the arbiter's radio port
`timescale 1ns/1ns
module rtma_radio_model (
  // clock
  input wire logic sys_clk,
  // inbound offer and bytes
  output logic radio_offer,
  input wire logic radio_offer_ok,
  input wire logic radio_offer_reject,
  output logic radio_rx_valid,
  output logic [7:0] radio_rx_data,
  output logic radio_rx_last,
  output logic radio_rx_err,
  input wire logic radio_rx_ready,
  // outbound bytes and call result
  input wire logic radio_tx_valid,
  input wire logic [7:0] radio_tx_data,
  input wire logic radio_tx_last,
  output logic radio_tx_ready,
  output logic radio_tx_abort,
  output logic radio_call_ok,
  output logic radio_call_fail
);
  logic [7:0] out_q[$]; // outbound bytes taken
  int abort_after = 0; // outbound abort after this many bytes, 0 none
  bit call_fail = 0; // result of the next call
  bit stall = 0; // ready only every other cycle, a slow radio
  bit dropped = 0; // outbound given up
  int wait_cnt = 0; // cycles until the call result
  logic rx_hs; // inbound byte taken at last edge
  initial begin
    {radio_offer, radio_rx_valid, radio_rx_last, radio_rx_err} = 4'h0;
    {radio_tx_ready, radio_tx_abort, radio_call_ok, radio_call_fail} = 4'h0;
    radio_rx_data = 8'h00;
  end
  // outbound side: collect bytes, then place the call
  always @(posedge sys_clk) begin
    rx_hs <= radio_rx_valid && radio_rx_ready;
    {radio_tx_abort, radio_call_ok, radio_call_fail} <= 3'h0;
    stall <= !stall;
    radio_tx_ready <= stall && !dropped;
    if (wait_cnt == 1) {radio_call_ok, radio_call_fail} <= {!call_fail, call_fail};
    if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
    if (radio_tx_valid && radio_tx_ready) begin
      out_q.push_back(radio_tx_data);
      if (out_q.size() == abort_after) begin
        radio_tx_abort <= 1'h1;
        dropped <= 1'h1;
      end else if (radio_tx_last) begin
        wait_cnt <= 4; // whole message held before the channel request
      end
    end
  end
  // offer one inbound call; entered just after a rising edge
  task automatic send_in(input int n, input logic [7:0] base, input int err_at, output bit ok);
    int guard;
    radio_offer = 1'h1;
    @(posedge sys_clk);
    #1 radio_offer = 1'h0;
    ok = radio_offer_ok;
    for (int i = 0; ok && i < n; i++) begin
      radio_rx_valid = 1'h1;
      radio_rx_data = base + 8'(i);
      radio_rx_last = (i == n - 1);
      radio_rx_err = (i == err_at);
      guard = 0;
      do begin
        @(posedge sys_clk);
        #1 guard++;
      end while (!rx_hs && guard < 300);
    end
    // released line shows no stale byte
    radio_rx_valid = 1'h0;
    radio_rx_data = ~radio_rx_data;
  endtask
endmodule // rtma_radio_model

/* File: tb/tb.sv */
// self-checking bench for the message arbiter
`timescale 1ns/1ns
`include "rtma_defs.svh"
module tb;
  localparam int DLY = 1; // drive offset after the rising edge
  logic sys_clk, rstn, anti_bias_jumper, term_xfer_req, term_accept, term_code_ready, term_code_valid;
  logic [1:0] mode_jumper, term_code, seen_code;
  logic term_rx_valid, term_rx_last, term_rx_ready, term_tx_valid, term_tx_last, term_tx_ready;
  logic [7:0] term_rx_data, term_tx_data, radio_rx_data, radio_tx_data, seen_data;
  logic radio_offer, radio_offer_ok, radio_offer_reject, radio_rx_valid, radio_rx_last, radio_rx_err;
  logic radio_rx_ready, radio_tx_valid, radio_tx_last, radio_tx_ready, radio_tx_abort;
  logic radio_call_ok, radio_call_fail, anti_bias_on, code_hs, rx_hs, tx_hs, seen_last;
  logic [3:0] radio_addr;
  logic [`RTMA_LEN_W:0] air_len;
  int n_mismatch = 0;
  int check_count = 0;
  int n_refuse = 0; // cycles the radio was held off
  bit ok;
  rtma_arbiter rtma_arbiter_inst (.*);
  rtma_radio_model rtma_radio_model_inst (.*);
  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end
  // handshakes as seen at the edge, read back just after it
  always @(posedge sys_clk) begin
    code_hs <= term_code_valid && term_code_ready;
    seen_code <= term_code;
    rx_hs <= term_rx_valid && term_rx_ready;
    tx_hs <= term_tx_valid && term_tx_ready;
    seen_data <= term_tx_data;
    seen_last <= term_tx_last;
    if (radio_rx_valid && !radio_rx_ready) n_refuse <= n_refuse + 1;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #DLY;
  endtask
  // bounded wait; running out counts as a mismatch
  task automatic hs_wait(ref logic f);
    int g = 0;
    do begin
      cyc(1);
      g++;
    end while (f !== 1'h1 && g < 400);
    if (g >= 400) check(16'h0000, 16'h0001);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask
  task automatic get_code(input logic [1:0] exp);
    term_code_ready = 1'h1;
    hs_wait(code_hs);
    term_code_ready = 1'h0;
    check(16'(seen_code), 16'(exp));
    cyc(1);
  endtask
  task automatic send_msg(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      term_rx_valid = 1'h1;
      term_rx_data = base + 8'(i);
      term_rx_last = (i == n - 1);
      hs_wait(rx_hs);
    end
    term_rx_valid = 1'h0;
    term_rx_data = ~term_rx_data;
  endtask
  task automatic recv_msg(input int n, input logic [7:0] base, input bit lst);
    term_tx_ready = 1'h1;
    for (int i = 0; i < n; i++) begin
      hs_wait(tx_hs);
      check(16'({seen_last, seen_data}), 16'({lst && i == n - 1, base + 8'(i)}));
    end
    term_tx_ready = 1'h0;
  endtask
  // reset for five cycles with new jumpers; clears the radio's state too
  task automatic restart(input logic [1:0] m, input logic b);
    rstn = 1'h0;
    mode_jumper = m;
    anti_bias_jumper = b;
    rtma_radio_model_inst.dropped = 0;
    rtma_radio_model_inst.abort_after = 0;
    rtma_radio_model_inst.call_fail = 0;
    rtma_radio_model_inst.out_q.delete();
    cyc(5);
    rstn = 1'h1;
    cyc(2);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    cyc(30000);
    n_mismatch++;
    conclude();
  end
  initial begin
    {rstn, term_xfer_req, term_accept, term_code_ready, term_rx_valid, term_rx_last, term_tx_ready} = 7'h00;
    term_rx_data = 8'h00;
    mode_jumper = `RTMA_MODE_TERM;
    anti_bias_jumper = 1'h0;
    #DLY;
    // each option mode, coding jumper both ways
    for (int m = 0; m < 4; m++) begin
      restart(2'(m), m[0]);
      check(16'(radio_addr), (m == 2) ? 16'(`RTMA_ADDR_VLOC) : 16'(`RTMA_ADDR_NORMAL));
      check(16'(anti_bias_on), 16'(m & 1));
    end
    // vehicle-location outbound, coded air length, failed call
    restart(`RTMA_MODE_VLOC, 1'h1);
    rtma_radio_model_inst.call_fail = 1;
    pulse(term_xfer_req);
    get_code(`RTMA_CODE_ACCEPT);
    send_msg(9, 8'h20);
    cyc(1);
    check(16'(air_len), 16'h000B);
    get_code(`RTMA_CODE_ABORT);
    for (int i = 0; i < 9; i++) check(16'(rtma_radio_model_inst.out_q[i]), 16'(8'h20 + 8'(i)));
    // both sides request: terminal wins, inbound held and offered later
    restart(`RTMA_MODE_TERM, 1'h0);
    rtma_radio_model_inst.send_in(4, 8'h40, -1, ok);
    check(16'(ok), 16'h0001);
    get_code(`RTMA_CODE_XFER);
    pulse(term_xfer_req);
    get_code(`RTMA_CODE_ACCEPT);
    send_msg(3, 8'h10);
    rtma_radio_model_inst.send_in(2, 8'h60, -1, ok);
    check(16'(ok), 16'h0000);
    get_code(`RTMA_CODE_SUCCESS);
    get_code(`RTMA_CODE_XFER);
    pulse(term_accept);
    recv_msg(4, 8'h40, 1);
    // request during inbound receive, then the radio drops the call
    restart(`RTMA_MODE_TERM, 1'h0);
    rtma_radio_model_inst.abort_after = 2;
    fork
      rtma_radio_model_inst.send_in(3, 8'h50, -1, ok);
      begin
        cyc(2);
        pulse(term_xfer_req);
        get_code(`RTMA_CODE_ACCEPT);
        send_msg(6, 8'h30);
      end
    join
    get_code(`RTMA_CODE_ABORT);
    get_code(`RTMA_CODE_XFER);
    pulse(term_accept);
    recv_msg(3, 8'h50, 1);
    check(16'(rtma_radio_model_inst.out_q.size()), 16'h0002);
    // converter priority: terminal's colliding request goes unanswered
    restart(`RTMA_MODE_CONV, 1'h0);
    rtma_radio_model_inst.send_in(2, 8'h70, -1, ok);
    get_code(`RTMA_CODE_XFER);
    pulse(term_xfer_req);
    cyc(3);
    check(16'(term_code_valid), 16'h0000);
    pulse(term_accept);
    recv_msg(2, 8'h70, 1);
    // printer: fifo fills and holds the radio off, error cuts the message
    restart(`RTMA_MODE_PRINT, 1'h0);
    n_refuse = 0;
    fork
      rtma_radio_model_inst.send_in(20, 8'h80, 18, ok);
      begin
        cyc(40);
        check(16'(n_refuse != 0), 16'h0001);
        recv_msg(18, 8'h80, 0);
      end
    join
    cyc(5);
    check(16'(term_tx_valid), 16'h0000);
    conclude();
  end
endmodule // tb
